// ==== inc/sldc_pkg.sv ====
// constants shared by the segment lcd frame and drive block
// assumes a single 250 mhz bus clock that also serves as the display source clock
package sldc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_A = 8'he4;
  localparam logic [7:0] IDX_FRAME_RATE = 8'he6;
  localparam logic [7:0] IDX_CONTRAST = 8'he7;
  localparam logic [7:0] IDX_MEM_BASE = 8'hec;
  localparam int MEM_BYTES = 20;
  localparam int BYTES_PER_COM = 5;
  localparam int SEG_COUNT = 40;

  // display_control_a fields
  localparam int CTRL_BLANK_BIT = 0;
  localparam int CTRL_IRQ_EN_BIT = 3;
  localparam int CTRL_DUTY_LSB = 4;
  localparam int CTRL_FLAG_BIT = 6;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;

  // frame_rate_config fields
  localparam int FRR_DIV_LSB = 0;
  localparam int FRR_TAP_LSB = 4;
  localparam logic [7:0] FRR_RESET = 8'h00;

  // contrast_drive_config fields
  localparam int CCR_LEVEL_LSB = 0;
  localparam int CCR_ZERO_BIT = 4;
  localparam int CCR_DRIVE_LSB = 5;
  localparam logic [7:0] CCR_RESET = 8'h00;
  localparam logic [2:0] DRIVE_HALF_CODE = 3'h7;

  // duty selection and last frame phase, one less than the frame length in prescaled ticks
  typedef enum logic [1:0] {
    SLDC_DUTY_STATIC = 2'h0,
    SLDC_DUTY_HALF = 2'h1,
    SLDC_DUTY_THIRD = 2'h2,
    SLDC_DUTY_QUARTER = 2'h3
  } sldc_duty_e;
  localparam logic [2:0] K_DEFAULT = 3'h7;
  localparam logic [2:0] K_THIRD = 3'h5;

  // timing: clock rate and nominal drive times in microseconds
  localparam int CLK_MHZ = 250;
  localparam int DRV_US_0 = 300;
  localparam int DRV_US_1 = 70;
  localparam int DRV_US_2 = 150;
  localparam int DRV_US_3 = 450;
  localparam int DRV_US_4 = 575;
  localparam int DRV_US_5 = 850;
  localparam int DRV_US_6 = 1150;
  localparam int DRV_W = 20;
  localparam int HALF_W = 16;

endpackage : sldc_pkg

// ==== src/sldc_clkdiv.sv ====
// prescaler and divide-by-d stage producing the prescaled display clock enable
// assumes tap and divide selects come straight from register flops
`timescale 1ns/1ps
module sldc_clkdiv (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] prescaler_tap_select,
  input wire logic [2:0] frame_divide_select,
  output logic prescaled_display_clock,
  output logic [sldc_pkg::HALF_W-1:0] half_period_cyc
);

  // low bits that must be all ones for a tap pulse, n = 2**width
  function automatic logic [11:0] sldc_tap_mask(input logic [2:0] sel);
    case (sel)
      3'h0: sldc_tap_mask = 12'h00f;
      3'h1: sldc_tap_mask = 12'h03f;
      3'h2: sldc_tap_mask = 12'h07f;
      3'h3: sldc_tap_mask = 12'h0ff;
      3'h4: sldc_tap_mask = 12'h1ff;
      3'h5: sldc_tap_mask = 12'h3ff;
      3'h6: sldc_tap_mask = 12'h7ff;
      default: sldc_tap_mask = 12'hfff;
    endcase
  endfunction : sldc_tap_mask

  logic [11:0] pre_cnt_reg;
  logic [2:0] div_cnt_reg;
  logic tap_pulse;
  logic [11:0] mask;

  assign mask = sldc_tap_mask(prescaler_tap_select);
  assign tap_pulse = (pre_cnt_reg & mask) == mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_reg <= 12'h000;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 12'h001;
    end
  end

  // divide by code plus one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 3'h0;
      prescaled_display_clock <= 1'b0;
    end else begin
      prescaled_display_clock <= 1'b0;
      if (tap_pulse) begin
        if (div_cnt_reg >= frame_divide_select) begin
          div_cnt_reg <= 3'h0;
          prescaled_display_clock <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 3'h1;
        end
      end
    end
  end

  // half of n*d cycles; n*d peaks at 32768 so half fits 16 bits
  always_comb begin
    logic [16:0] full;
    full = 17'({5'h00, mask} + 17'h1) * 17'({14'h0, frame_divide_select} + 17'h1);
    half_period_cyc = full[16:1];
  end

  a_tick_single: assert property (@(posedge hclk) disable iff (!hresetn)
    prescaled_display_clock |=> !prescaled_display_clock)
    else $error("prescaled tick lasted more than one cycle");

endmodule : sldc_clkdiv

// ==== src/sldc_top.sv ====
// segment lcd frame timing, drive time, contrast and display memory
// assumes an ahb-lite master with single word transfers and hclk as display source
//
// How it works
// - divide prescaler output by code plus one
// - frame rate is source over k*n*d
// - k is six at third duty, else eight
// - drive code picks nominal on-time, 111 half
// - on-time ends by half prescaled period unless the period shrinks mid-pulse
// - static or blanked uses half period drive
// - new drive code acts at once
// - contrast code sets maximum drive voltage
// - contrast code applied at frame start only
// - contrast register bit four reads zero
// - memory one energizes segment on its common
// - unused memory bits are plain storage
// - twenty bytes, five per common, reset zero
// - blanking starts after frame ends, outputs ground
// - tap select chooses prescaler output
// - frame interrupt when enabled and global on
`timescale 1ns/1ps
module sldc_top #(
  parameter int DRV_CYC_0 = sldc_pkg::DRV_US_0 * sldc_pkg::CLK_MHZ,
  parameter int DRV_CYC_1 = sldc_pkg::DRV_US_1 * sldc_pkg::CLK_MHZ,
  parameter int DRV_CYC_2 = sldc_pkg::DRV_US_2 * sldc_pkg::CLK_MHZ,
  parameter int DRV_CYC_3 = sldc_pkg::DRV_US_3 * sldc_pkg::CLK_MHZ,
  parameter int DRV_CYC_4 = sldc_pkg::DRV_US_4 * sldc_pkg::CLK_MHZ,
  parameter int DRV_CYC_5 = sldc_pkg::DRV_US_5 * sldc_pkg::CLK_MHZ,
  parameter int DRV_CYC_6 = sldc_pkg::DRV_US_6 * sldc_pkg::CLK_MHZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic global_irq_enable,
  output logic frame_irq,
  output logic start_of_frame,
  output logic [3:0] max_drive_voltage,
  output logic drive_enable,
  output logic drive_polarity,
  output logic [3:0] common_out,
  output logic [sldc_pkg::SEG_COUNT-1:0] segment_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register address decode

  // word index of a byte address; only the low ten bits map
  function automatic logic [7:0] sldc_word_idx(input logic [31:0] addr);
    sldc_word_idx = addr[9:2];
  endfunction : sldc_word_idx

  function automatic logic sldc_is_mem(input logic [7:0] idx);
    sldc_is_mem = (idx >= sldc_pkg::IDX_MEM_BASE) &&
                  (9'(idx) < 9'(sldc_pkg::IDX_MEM_BASE) + 9'(sldc_pkg::MEM_BYTES));
  endfunction : sldc_is_mem

  logic [7:0] ctrl_a_reg;
  logic [7:0] frame_rate_reg;
  logic [7:0] contrast_reg;
  logic [7:0] mem_reg [0:sldc_pkg::MEM_BYTES-1];
  logic frame_flag_reg;
  logic [7:0] wr_idx_reg;
  logic wr_pend_reg;
  logic addr_ok;
  logic [7:0] a_idx;
  logic [4:0] a_mem;
  logic [4:0] w_mem;
  logic wr_ctrl;
  logic wr_mem;
  logic sof_pulse;

  assign addr_ok = hsel && hready && htrans[1];
  assign a_idx = sldc_word_idx(haddr);
  assign a_mem = 5'(a_idx - sldc_pkg::IDX_MEM_BASE);
  assign w_mem = 5'(wr_idx_reg - sldc_pkg::IDX_MEM_BASE);
  assign wr_ctrl = wr_pend_reg && (wr_idx_reg == sldc_pkg::IDX_CTRL_A);
  assign wr_mem = wr_pend_reg && sldc_is_mem(wr_idx_reg);

  // zero wait states, always okay; unmapped reads return zero
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: address phase capture and read data

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_idx_reg <= a_idx;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (a_idx == sldc_pkg::IDX_CTRL_A) begin
        hrdata[7:0] <= {ctrl_a_reg[7], frame_flag_reg, ctrl_a_reg[5:0]};
      end else if (a_idx == sldc_pkg::IDX_FRAME_RATE) begin
        hrdata[7:0] <= frame_rate_reg;
      end else if (a_idx == sldc_pkg::IDX_CONTRAST) begin
        hrdata[7:0] <= contrast_reg;
      end else if (sldc_is_mem(a_idx)) begin
        hrdata[7:0] <= mem_reg[a_mem];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a_reg <= sldc_pkg::CTRL_A_RESET;
    end else if (wr_ctrl) begin
      // flag bit and reserved bits 2:1 and 7 hold no storage
      ctrl_a_reg <= hwdata[7:0] & 8'h39;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_rate_reg <= sldc_pkg::FRR_RESET;
    end else if (wr_pend_reg && wr_idx_reg == sldc_pkg::IDX_FRAME_RATE) begin
      frame_rate_reg <= hwdata[7:0] & 8'h77;
    end
  end

  // drive code acts at once; contrast level waits for the frame pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      contrast_reg <= sldc_pkg::CCR_RESET;
    end else if (wr_pend_reg && wr_idx_reg == sldc_pkg::IDX_CONTRAST) begin
      contrast_reg <= hwdata[7:0] & 8'hef;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < sldc_pkg::MEM_BYTES; i++) begin
        mem_reg[i] <= 8'h00;
      end
    end else if (wr_mem) begin
      mem_reg[w_mem] <= hwdata[7:0];
    end
  end

  // sticky frame flag, write one clears, a new frame wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_flag_reg <= 1'b0;
    end else if (sof_pulse) begin
      frame_flag_reg <= 1'b1;
    end else if (wr_ctrl && hwdata[sldc_pkg::CTRL_FLAG_BIT]) begin
      frame_flag_reg <= 1'b0;
    end
  end

  assign frame_irq = frame_flag_reg && ctrl_a_reg[sldc_pkg::CTRL_IRQ_EN_BIT] &&
                     global_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // prescaled clock and frame sequencing

  logic ps_tick;
  logic [sldc_pkg::HALF_W-1:0] half_cyc;
  logic [1:0] duty;
  logic [2:0] k_last;
  logic [2:0] phase_reg;
  logic blank_active_reg;

  sldc_clkdiv u_clkdiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .prescaler_tap_select(frame_rate_reg[sldc_pkg::FRR_TAP_LSB +: 3]),
    .frame_divide_select(frame_rate_reg[sldc_pkg::FRR_DIV_LSB +: 3]),
    .prescaled_display_clock(ps_tick),
    .half_period_cyc(half_cyc)
  );

  assign duty = ctrl_a_reg[sldc_pkg::CTRL_DUTY_LSB +: 2];
  assign k_last = (duty == sldc_pkg::SLDC_DUTY_THIRD) ? sldc_pkg::K_THIRD
                                                       : sldc_pkg::K_DEFAULT;

  // k prescaled ticks per frame gives source / (k*n*d)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= 3'h0;
      sof_pulse <= 1'b0;
    end else begin
      sof_pulse <= 1'b0;
      if (ps_tick) begin
        if (phase_reg >= k_last) begin
          phase_reg <= 3'h0;
          sof_pulse <= 1'b1;
        end else begin
          phase_reg <= phase_reg + 3'h1;
        end
      end
    end
  end

  assign start_of_frame = sof_pulse;

  // contrast and blanking both change only between frames
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      max_drive_voltage <= 4'h0;
      blank_active_reg <= 1'b0;
    end else if (sof_pulse) begin
      max_drive_voltage <= contrast_reg[sldc_pkg::CCR_LEVEL_LSB +: 4];
      blank_active_reg <= ctrl_a_reg[sldc_pkg::CTRL_BLANK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // driver on-time

  logic [2:0] drv_code;
  logic [sldc_pkg::DRV_W-1:0] nominal_cyc;
  logic [sldc_pkg::DRV_W-1:0] half_ext;
  logic [sldc_pkg::DRV_W-1:0] drive_limit;
  logic [sldc_pkg::DRV_W-1:0] drive_cnt_reg;

  assign drv_code = contrast_reg[sldc_pkg::CCR_DRIVE_LSB +: 3];
  assign half_ext = sldc_pkg::DRV_W'(half_cyc);

  always_comb begin
    case (drv_code)
      3'h0: nominal_cyc = sldc_pkg::DRV_W'(DRV_CYC_0);
      3'h1: nominal_cyc = sldc_pkg::DRV_W'(DRV_CYC_1);
      3'h2: nominal_cyc = sldc_pkg::DRV_W'(DRV_CYC_2);
      3'h3: nominal_cyc = sldc_pkg::DRV_W'(DRV_CYC_3);
      3'h4: nominal_cyc = sldc_pkg::DRV_W'(DRV_CYC_4);
      3'h5: nominal_cyc = sldc_pkg::DRV_W'(DRV_CYC_5);
      3'h6: nominal_cyc = sldc_pkg::DRV_W'(DRV_CYC_6);
      default: nominal_cyc = half_ext;
    endcase
  end

  always_comb begin
    if (duty == sldc_pkg::SLDC_DUTY_STATIC || blank_active_reg ||
        drv_code == sldc_pkg::DRIVE_HALF_CODE) begin
      drive_limit = half_ext;
    end else if (nominal_cyc > half_ext) begin
      drive_limit = half_ext;
    end else begin
      drive_limit = nominal_cyc;
    end
  end

  // a limit change mid-pulse is compared at once, hence possible glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_enable <= 1'b0;
      drive_cnt_reg <= '0;
    end else if (ps_tick) begin
      drive_enable <= 1'b1;
      drive_cnt_reg <= '0;
    end else if (drive_enable) begin
      if (drive_cnt_reg + 1'b1 >= drive_limit) begin
        drive_enable <= 1'b0;
      end else begin
        drive_cnt_reg <= drive_cnt_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // common and segment outputs

  logic [1:0] com_idx;
  logic [sldc_pkg::SEG_COUNT-1:0] row_bits;

  always_comb begin
    case (duty)
      sldc_pkg::SLDC_DUTY_STATIC: com_idx = 2'h0;
      sldc_pkg::SLDC_DUTY_HALF: com_idx = {1'b0, phase_reg[2]};
      default: com_idx = phase_reg[2:1];
    endcase
  end

  // byte 5n+k holds segments 8k..8k+7 of common n, lsb lowest
  always_comb begin
    row_bits = '0;
    for (int k = 0; k < sldc_pkg::BYTES_PER_COM; k++) begin
      row_bits[8*k +: 8] = mem_reg[sldc_pkg::BYTES_PER_COM * com_idx + k];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      common_out <= 4'h0;
      segment_out <= '0;
      drive_polarity <= 1'b0;
    end else if (blank_active_reg) begin
      common_out <= 4'h0;
      segment_out <= '0;
      drive_polarity <= 1'b0;
    end else begin
      common_out <= 4'h1 << com_idx;
      segment_out <= row_bits;
      drive_polarity <= phase_reg[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_contrast_at_frame: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(max_drive_voltage) |-> $past(sof_pulse))
    else $error("contrast changed outside a frame start");

  a_bit4_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && a_idx == sldc_pkg::IDX_CONTRAST) |=> !hrdata[4])
    else $error("contrast bit four read as one");

  a_blank_grounds: assert property (@(posedge hclk) disable iff (!hresetn)
    blank_active_reg |=> (common_out == 4'h0 && segment_out == '0))
    else $error("outputs not grounded while blanked");

  a_blank_at_frame: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(blank_active_reg) |-> $past(sof_pulse))
    else $error("blanking began mid-frame");

  // a shrinking period may leave one late cycle, so the cap is checked on the step
  a_drive_capped: assert property (@(posedge hclk) disable iff (!hresetn)
    (drive_enable && !ps_tick && (drive_cnt_reg + 20'h1 >= half_ext)) |=>
    !drive_enable)
    else $error("drive on-time passed half period");

  a_static_half: assert property (@(posedge hclk) disable iff (!hresetn)
    ($fell(drive_enable) && !$past(ps_tick) && duty == sldc_pkg::SLDC_DUTY_STATIC &&
     $stable(half_ext)) |-> $past(drive_cnt_reg) == half_ext - 1'b1)
    else $error("static drive did not end at half period");

  a_mem_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mem |=> mem_reg[$past(w_mem)] == $past(hwdata[7:0]))
    else $error("display memory write lost");

  a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    frame_irq |-> (frame_flag_reg && global_irq_enable &&
                   ctrl_a_reg[sldc_pkg::CTRL_IRQ_EN_BIT]))
    else $error("frame interrupt raised while disabled");

  a_sof_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    sof_pulse |=> frame_flag_reg ##0 !sof_pulse)
    else $error("frame pulse did not set flag or lasted two cycles");

  // a switch into third duty may find the phase above five, which wraps at once
  a_frame_phase: assert property (@(posedge hclk) disable iff (!hresetn)
    (ps_tick && duty == sldc_pkg::SLDC_DUTY_THIRD) |=>
    (sof_pulse == ($past(phase_reg) >= 3'h5)))
    else $error("third duty frame not six ticks");

  c_frame: cover property (@(posedge hclk) disable iff (!hresetn) sof_pulse);
  c_blank: cover property (@(posedge hclk) disable iff (!hresetn) $rose(blank_active_reg));
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(frame_irq));

endmodule : sldc_top

// ==== tb/sldc_glass_model.sv ====
// passive glass panel model: keeps the last row seen on each common
// assumes one-hot commons with the segment row valid while a common is active
`timescale 1ns/1ps
module sldc_glass_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] common_out,
  input wire logic [sldc_pkg::SEG_COUNT-1:0] segment_out,
  output logic [4*sldc_pkg::SEG_COUNT-1:0] lit_image
);
  ////////////////////////////////////////////////////////////////////////////////
  // glass only responds to voltage, so a row is what the drivers showed it last
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lit_image <= '0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (common_out[n]) begin
          lit_image[n*sldc_pkg::SEG_COUNT +: sldc_pkg::SEG_COUNT] <= segment_out;
        end
      end
    end
  end
endmodule : sldc_glass_model

// ==== tb/test_segment_lcd_frame_and_drive_control.sv ====
// register, frame, drive and segment tests for the segment lcd block
// assumes tap 0 gives n=16 and shortened drive counts on the instance
`timescale 1ns/1ps
module test_segment_lcd_frame_and_drive_control;
  localparam int DRV [7] = '{10, 3, 5, 12, 14, 20, 28};
  localparam logic [7:0] CA = sldc_pkg::IDX_CTRL_A;
  localparam logic [7:0] FR = sldc_pkg::IDX_FRAME_RATE;
  localparam logic [7:0] CC = sldc_pkg::IDX_CONTRAST;
  localparam logic [7:0] MB = sldc_pkg::IDX_MEM_BASE;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic global_irq_enable, frame_irq, start_of_frame, drive_enable, drive_polarity;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] max_drive_voltage, common_out;
  logic [39:0] segment_out, row;
  logic [159:0] lit_image;
  logic [7:0] mem [20];
  int failures, comparisons, n;
  assign hready = hreadyout;

  sldc_top #(.DRV_CYC_0(DRV[0]), .DRV_CYC_1(DRV[1]), .DRV_CYC_2(DRV[2]), .DRV_CYC_3(DRV[3]),
    .DRV_CYC_4(DRV[4]), .DRV_CYC_5(DRV[5]), .DRV_CYC_6(DRV[6])) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .global_irq_enable(global_irq_enable), .frame_irq(frame_irq),
    .start_of_frame(start_of_frame), .max_drive_voltage(max_drive_voltage),
    .drive_enable(drive_enable), .drive_polarity(drive_polarity), .common_out(common_out),
    .segment_out(segment_out)
  );
  sldc_glass_model glass (.hclk(hclk), .hresetn(hresetn), .common_out(common_out),
    .segment_out(segment_out), .lit_image(lit_image));

  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tally_and_finish;
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // one single word transfer; address held until hready, data until hready
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task rchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp});
  endtask : rchk

  task wait_sof;
    do @(posedge hclk); while (start_of_frame !== 1'b1);
  endtask : wait_sof

  // first frame after a change may be short, so the third pulse is timed
  task frame_len;
    wait_sof;
    wait_sof;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (start_of_frame !== 1'b1);
  endtask : frame_len

  // a fresh pulse only, since a code change may cut the running one
  task drive_len;
    do @(posedge hclk); while (drive_enable !== 1'b0);
    do @(posedge hclk); while (drive_enable !== 1'b1);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (drive_enable === 1'b1);
  endtask : drive_len

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    repeat (60000) @(posedge hclk);
    failures++;
    tally_and_finish;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    global_irq_enable = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({hreadyout, hresp}, 2'h2);
    rchk(CA, 8'h00);
    rchk(FR, 8'h00);
    rchk(CC, 8'h00);
    for (int i = 0; i < 20; i++) rchk(MB + 8'(i), 8'h00);
    wr(CC, 8'hff);
    rchk(CC, 8'hef);
    wr(FR, 8'hff);
    rchk(FR, 8'h77);
    wr(8'he8, 8'ha5);
    rchk(8'he8, 8'h00);
    // every byte given a distinct value, used or not
    for (int i = 0; i < 20; i++) mem[i] = 8'(i * 59 + 129);
    for (int i = 0; i < 20; i++) wr(MB + 8'(i), mem[i]);
    for (int i = 0; i < 20; i++) rchk(MB + 8'(i), mem[i]);
    wr(CA, 8'h30);
    for (int d = 0; d < 8; d++) begin
      wr(FR, 8'(d));
      frame_len;
      check(n, 128 * (d + 1));
    end
    wr(CA, 8'h20);
    wr(FR, 8'h03);
    frame_len;
    check(n, 384);
    wr(CA, 8'h10);
    frame_len;
    check(n, 512);
    wr(CA, 8'h30);
    wr(FR, 8'h10);
    frame_len;
    check(n, 512);
    wait_sof;
    wait_sof;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 5; k++) row[8*k +: 8] = mem[5*c+k];
      check(lit_image[40*c +: 40], row);
    end
    // first tick after the frame start gives odd phase parity
    do @(posedge hclk); while (drive_enable !== 1'b0);
    do @(posedge hclk); while (drive_enable !== 1'b1);
    #1;
    check(drive_polarity, 1'b1);
    // d=8 gives a half period of 64, longer than every shortened count
    wr(FR, 8'h07);
    for (int code = 0; code < 7; code++) begin
      wr(CC, {3'(code), 5'h00});
      drive_len;
      check(n, DRV[code]);
    end
    wr(CC, 8'he0);
    drive_len;
    check(n, 64);
    wr(CA, 8'h00);
    wr(CC, 8'h20);
    drive_len;
    check(n, 64);
    wr(CA, 8'h30);
    wr(FR, 8'h00);
    wr(CC, 8'hc0);
    drive_len;
    check(n, 8);
    wr(FR, 8'h07);
    wait_sof;
    wr(CA, 8'h31);
    check(common_out != 4'h0, 1'b1);
    wait_sof;
    @(posedge hclk);
    #1;
    check({common_out, segment_out}, 44'h0);
    wr(CC, 8'h2a);
    repeat (2) @(posedge hclk);
    check(max_drive_voltage, 4'h0);
    drive_len;
    check(n, 64);
    wait_sof;
    #1;
    check(max_drive_voltage, 4'ha);
    wr(CA, 8'h38);
    global_irq_enable <= 1'b1;
    wait_sof;
    repeat (2) @(posedge hclk);
    check(frame_irq, 1'b1);
    rchk(CA, 8'h78);
    global_irq_enable <= 1'b0;
    @(posedge hclk);
    #1;
    check(frame_irq, 1'b0);
    wr(CA, 8'h78);
    global_irq_enable <= 1'b1;
    @(posedge hclk);
    #1;
    check(frame_irq, 1'b0);
    tally_and_finish;
  end
endmodule : test_segment_lcd_frame_and_drive_control
